// >>> safing_pkg.sv
// Package of constants and types for the safing supervisor.
//
// Operation
// - Release of the state-machine reset puts the machine in start-up mode.
// - Start-up mode takes no samples and keeps arm and n_out_a inactive.
// - Threshold writes are accepted only in start-up mode, refused elsewhere.
// - First successful watchdog service moves start-up to diagnostic mode.
// - Diagnostic mode lets host drive outputs both high or both low only.
// - Diagnostic mode waits for a control command; safing field enters safing mode.
// - Safing mode is left only by the state-machine reset.
// - Control command selecting scrap in diagnostic mode enters scrap mode.
// - Scrap mode ignores sensors and disables threshold comparison.
// - Scrap leaves to arming only by handshake, to start-up only by reset.
// - Arming mode holds arm high and active-low n_out_a low.
// - Seed comes from a free-running 8-bit counter, returned on seed request.
// - Submitted key is checked against key computed from the last read seed.
// - Arming needs matching key and valid arming-confirm signal together.
// - Expected key is the seed exclusive-or 0x55.
// - Wrong key, timeout or missing confirm returns arming to scrap mode.
// - Sequence ids map pairwise to thresholds 0 to 6; id 1110 to 7.
// - Three consecutive exceeding samples set safing; outputs follow plus dwell.
// - Dwell extension is 255 ms or 2.0 s, chosen by threshold top bit.
// - Sequence counter advances per response; mismatch sets error, disables safing; the code only stops comparison, a full run keeps safing set.
// - Sequence counter resets to 1111 so first sample makes it 0000.
package safing_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned SCRAP_TIMEOUT_US = 600;
  localparam int unsigned DWELL_SHORT_MS   = 255;
  localparam int unsigned DWELL_LONG_MS    = 2000;
  localparam int unsigned SCRAP_TIMEOUT_CYC = SCRAP_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DWELL_SHORT_CYC  = DWELL_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned DWELL_LONG_CYC   = DWELL_LONG_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_MASK       = 8'h55;
  localparam logic [3:0] SEQ_RESET      = 4'hf;
  localparam logic [3:0] SEQ_FROZEN     = 4'he;
  localparam logic [3:0] VALID_RESET    = 4'h0;
  localparam logic [7:0] SEED_RESET     = 8'h00;
  localparam logic [7:0] THRESH_RESET   = 8'h0d;
  localparam int unsigned NUM_THRESH    = 8;
  localparam int unsigned DWELL_SEL_BIT = 7;
  localparam logic [1:0] HIT_COUNT      = 2'h3;

  typedef enum logic [2:0] {
    MODE_STARTUP = 3'b000,
    MODE_DIAG    = 3'b001,
    MODE_SAFING  = 3'b010,
    MODE_SCRAP   = 3'b011,
    MODE_ARMING  = 3'b100
  } mode_type;

  typedef enum logic [1:0] {
    REQ_NONE   = 2'b00,
    REQ_SAFING = 2'b01,
    REQ_SCRAP  = 2'b10
  } mode_request_type;

endpackage

// >>> safing_fsm.sv
// Safing supervisor: mode machine, key handshake, sensor comparison and dwell.
`timescale 1ns/10ps
`default_nettype none
module safing_fsm #(
  parameter int unsigned SCRAP_TIMEOUT_CYC = safing_pkg::SCRAP_TIMEOUT_CYC,
  parameter int unsigned DWELL_SHORT_CYC   = safing_pkg::DWELL_SHORT_CYC,
  parameter int unsigned DWELL_LONG_CYC    = safing_pkg::DWELL_LONG_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       fsm_reset_n,
  input  wire logic       watchdog_fed,
  input  wire logic       control_valid,
  input  wire logic [1:0] mode_request_field,
  input  wire logic       test_arm,
  input  wire logic       test_n_out_a,
  input  wire logic       thresh_wr,
  input  wire logic [2:0] thresh_idx,
  input  wire logic [7:0] thresh_data,
  input  wire logic       seed_req,
  input  wire logic       key_valid,
  input  wire logic [7:0] key_data,
  input  wire logic       arming_confirm_signal,
  input  wire logic       sync_in,
  input  wire logic       sample_valid,
  input  wire logic       sample_data_ok,
  input  wire logic [2:0] sequence_id_field,
  input  wire logic [9:0] sample_data,
  output logic            arm,
  output logic            n_out_a,
  output logic [7:0]      seed_out,
  output logic            thresh_wr_refused,
  output logic            sequence_error_flag,
  output logic [3:0]      valid_count,
  output logic [2:0]      mode_out
);

  // ----------------------------------------------------------------
  // Input synchronisers for pins
  // ----------------------------------------------------------------
  logic [1:0] fres_sync_reg;
  logic [1:0] confirm_sync_reg;
  logic [1:0] sync_sync_reg;
  logic       sync_prev_reg;
  logic       fsm_rst_active;
  logic       confirm_ok;
  logic       sync_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fres_sync_reg    <= 2'h0;
      confirm_sync_reg <= 2'h0;
      sync_sync_reg    <= 2'h0;
      sync_prev_reg    <= 1'b0;
    end else begin
      fres_sync_reg    <= {fres_sync_reg[0], fsm_reset_n};
      confirm_sync_reg <= {confirm_sync_reg[0], arming_confirm_signal};
      sync_sync_reg    <= {sync_sync_reg[0], sync_in};
      sync_prev_reg    <= sync_sync_reg[1];
    end
  end

  assign fsm_rst_active = !fres_sync_reg[1];
  assign confirm_ok     = confirm_sync_reg[1];
  assign sync_rise      = sync_sync_reg[1] && !sync_prev_reg;

  // ----------------------------------------------------------------
  // Mode machine
  // ----------------------------------------------------------------
  safing_pkg::mode_type mode_reg;
  safing_pkg::mode_type mode_next;
  logic [7:0]  seed_reg;
  logic [7:0]  frozen_seed_reg;
  logic        key_good;
  logic [15:0] scrap_timer_reg;
  logic        scrap_expired;

  // The key is checked against the seed the host last read, not the live count.
  assign key_good = (key_data == (frozen_seed_reg ^ safing_pkg::KEY_MASK));
  assign scrap_expired = (scrap_timer_reg == 16'h0000);

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      safing_pkg::MODE_STARTUP: begin
        if (watchdog_fed) begin
          mode_next = safing_pkg::MODE_DIAG;
        end
      end
      safing_pkg::MODE_DIAG: begin
        if (control_valid && mode_request_field == safing_pkg::REQ_SAFING) begin
          mode_next = safing_pkg::MODE_SAFING;
        end else if (control_valid && mode_request_field == safing_pkg::REQ_SCRAP) begin
          mode_next = safing_pkg::MODE_SCRAP;
        end
      end
      safing_pkg::MODE_SAFING: begin
        mode_next = safing_pkg::MODE_SAFING;
      end
      safing_pkg::MODE_SCRAP: begin
        if (key_valid && key_good && confirm_ok) begin
          mode_next = safing_pkg::MODE_ARMING;
        end
      end
      safing_pkg::MODE_ARMING: begin
        if ((key_valid && !key_good) || !confirm_ok || scrap_expired) begin
          mode_next = safing_pkg::MODE_SCRAP;
        end
      end
      default: begin
        mode_next = safing_pkg::MODE_STARTUP;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= safing_pkg::MODE_STARTUP;
    end else if (fsm_rst_active) begin
      mode_reg <= safing_pkg::MODE_STARTUP;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Timeout reloads on every good refresh while arming. A zero count reads as
  // expired, so arming can never be held by a timer that was never loaded.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scrap_timer_reg <= 16'h0000;
    end else if (mode_next == safing_pkg::MODE_ARMING &&
                 (mode_reg != safing_pkg::MODE_ARMING || (key_valid && key_good))) begin
      scrap_timer_reg <= 16'(SCRAP_TIMEOUT_CYC);
    end else if (!scrap_expired) begin
      scrap_timer_reg <= scrap_timer_reg - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Seed generator
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seed_reg        <= safing_pkg::SEED_RESET;
      frozen_seed_reg <= safing_pkg::SEED_RESET;
    end else begin
      seed_reg <= seed_reg + 8'h01;
      if (seed_req) begin
        frozen_seed_reg <= seed_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Thresholds
  // ----------------------------------------------------------------
  logic [7:0] thresh_reg [safing_pkg::NUM_THRESH];

  generate
    for (genvar g = 0; g < safing_pkg::NUM_THRESH; g++) begin : g_thresh
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          thresh_reg[g] <= safing_pkg::THRESH_RESET;
        end else if (fsm_rst_active) begin
          thresh_reg[g] <= safing_pkg::THRESH_RESET;
        end else if (thresh_wr && thresh_idx == 3'(g) &&
                     mode_reg == safing_pkg::MODE_STARTUP) begin
          thresh_reg[g] <= thresh_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thresh_wr_refused <= 1'b0;
    end else begin
      thresh_wr_refused <= thresh_wr && mode_reg != safing_pkg::MODE_STARTUP;
    end
  end

  // ----------------------------------------------------------------
  // Sequence and valid-data counters
  // ----------------------------------------------------------------
  logic       sampling;
  logic       sens_msg;
  logic [3:0] seq_reg;
  logic [3:0] seq_now;
  logic       seq_err_reg;
  logic       seq_mismatch;

  // Only safing mode samples; start-up and scrap ignore the sensors.
  assign sampling     = (mode_reg == safing_pkg::MODE_SAFING);
  assign sens_msg     = sampling && sample_valid && seq_reg != safing_pkg::SEQ_FROZEN;
  assign seq_now      = seq_reg + 4'h1;
  assign seq_mismatch = sens_msg && (sequence_id_field != seq_now[2:0]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg     <= safing_pkg::SEQ_RESET;
      valid_count <= safing_pkg::VALID_RESET;
      seq_err_reg <= 1'b0;
    end else if (sync_rise || fsm_rst_active) begin
      seq_reg     <= safing_pkg::SEQ_RESET;
      valid_count <= safing_pkg::VALID_RESET;
      seq_err_reg <= 1'b0;
    end else if (sens_msg) begin
      seq_reg <= seq_now;
      if (seq_mismatch) begin
        seq_err_reg <= 1'b1;
      end
      if (sample_data_ok && !seq_mismatch && !seq_err_reg) begin
        valid_count <= valid_count + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sequence_error_flag <= 1'b0;
    end else begin
      sequence_error_flag <= seq_err_reg || seq_mismatch;
    end
  end

  // ----------------------------------------------------------------
  // Threshold comparison
  // ----------------------------------------------------------------
  // Runs are kept per sensor slot, not per threshold: two sensors that share a
  // threshold must not break each other's run of exceeding samples.
  localparam int unsigned NUM_SLOTS = 2 * safing_pkg::NUM_THRESH;

  logic [2:0]           tidx;
  logic [7:0]           tsel;
  logic                 data_good;
  logic                 exceed;
  logic [1:0]           hit_reg [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] streak_full;
  logic                 safe_reg;
  logic                 long_sel_reg;

  assign tidx      = seq_now[3:1];
  assign tsel      = thresh_reg[tidx];
  assign data_good = sens_msg && sample_data_ok && !seq_mismatch && !seq_err_reg;
  // Low seven bits of the threshold scale to the 10-bit signed sample range.
  assign exceed    = !sample_data[9] && (sample_data[8:0] > {tsel[6:0], 2'b00});

  generate
    for (genvar h = 0; h < NUM_SLOTS; h++) begin : g_hits
      // A sample at or below its threshold restarts that sensor's run.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          hit_reg[h] <= 2'h0;
        end else if (!sampling) begin
          hit_reg[h] <= 2'h0;
        end else if (data_good && seq_now == 4'(h)) begin
          if (!exceed) begin
            hit_reg[h] <= 2'h0;
          end else if (hit_reg[h] != safing_pkg::HIT_COUNT) begin
            hit_reg[h] <= hit_reg[h] + 2'h1;
          end
        end
      end
      assign streak_full[h] = (hit_reg[h] == safing_pkg::HIT_COUNT);
    end
  endgenerate

  // The safing signal lasts while any sensor keeps its full run of exceeding samples.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      safe_reg     <= 1'b0;
      long_sel_reg <= 1'b0;
    end else if (!sampling) begin
      safe_reg <= 1'b0;
    end else begin
      safe_reg <= |streak_full;
      if (data_good && exceed && hit_reg[seq_now] == safing_pkg::HIT_COUNT - 2'h1) begin
        long_sel_reg <= tsel[safing_pkg::DWELL_SEL_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Dwell extension
  // ----------------------------------------------------------------
  logic [27:0] dwell_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dwell_reg <= 28'h0;
    end else if (!sampling) begin
      dwell_reg <= 28'h0;
    end else if (safe_reg) begin
      dwell_reg <= long_sel_reg ? 28'(DWELL_LONG_CYC) : 28'(DWELL_SHORT_CYC);
    end else if (dwell_reg != 28'h0) begin
      dwell_reg <= dwell_reg - 28'h1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm     <= 1'b0;
      n_out_a <= 1'b1;
    end else begin
      unique case (mode_reg)
        safing_pkg::MODE_DIAG: begin
          // Both-equal levels only; the active pair is never let through.
          arm     <= test_arm && test_n_out_a;
          n_out_a <= test_arm && test_n_out_a;
        end
        safing_pkg::MODE_SAFING: begin
          arm     <= safe_reg || dwell_reg != 28'h0;
          n_out_a <= !(safe_reg || dwell_reg != 28'h0);
        end
        safing_pkg::MODE_ARMING: begin
          arm     <= 1'b1;
          n_out_a <= 1'b0;
        end
        default: begin
          arm     <= 1'b0;
          n_out_a <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seed_out <= safing_pkg::SEED_RESET;
      mode_out <= 3'h0;
    end else begin
      if (seed_req) begin
        seed_out <= seed_reg;
      end
      mode_out <= mode_reg;
    end
  end

endmodule // safing_fsm
`default_nettype wire

// >>> safing_props.sv
// Port-level assertions and cover points for the safing supervisor.
`timescale 1ns/10ps
`default_nettype none
module safing_props #(
  parameter int unsigned SCRAP_TIMEOUT_CYC = 50
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       fsm_reset_n,
  input wire logic       watchdog_fed,
  input wire logic       seed_req,
  input wire logic       key_valid,
  input wire logic       thresh_wr,
  input wire logic       arm,
  input wire logic       n_out_a,
  input wire logic [7:0] seed_out,
  input wire logic       thresh_wr_refused,
  input wire logic       sequence_error_flag,
  input wire logic [2:0] mode_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Cycles spent armed without a key; the margin covers the mode report latency.
  logic [15:0] idle_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_reg <= 16'h0000;
    end else if (mode_out != 3'h4 || key_valid) begin
      idle_reg <= 16'h0000;
    end else begin
      idle_reg <= idle_reg + 16'h0001;
    end
  end

  chk_reset_startup: assert property (
    !fsm_reset_n [*3] |-> ##[1:6] mode_out == 3'h0) else $error("mode not start-up after reset");
  chk_startup_quiet: assert property (
    mode_out == 3'h0 && $past(mode_out, 2) == 3'h0 |-> !arm && n_out_a)
    else $error("outputs active in start-up");
  chk_write_refuse: assert property (
    thresh_wr |=> thresh_wr_refused == ($past(mode_out) != 3'h0))
    else $error("threshold write refusal wrong");
  chk_diag_entry: assert property (
    mode_out == 3'h0 && watchdog_fed |-> ##[1:2] mode_out == 3'h1)
    else $error("no diagnostic entry after watchdog");
  chk_diag_not_armed: assert property (
    mode_out == 3'h1 && $past(mode_out, 2) == 3'h1 |-> !(arm && !n_out_a))
    else $error("both outputs active in diagnostic");
  chk_safing_sticky: assert property (
    $past(mode_out) == 3'h2 |-> mode_out inside {3'h0, 3'h2}) else $error("safing mode left");
  chk_scrap_exits: assert property (
    $past(mode_out) == 3'h3 |-> mode_out inside {3'h0, 3'h3, 3'h4})
    else $error("illegal exit from scrap");
  chk_arming_outputs: assert property (
    mode_out == 3'h4 && $past(mode_out) == 3'h4 |-> arm && !n_out_a)
    else $error("arming outputs not asserted");
  chk_timeout_exit: assert property (
    idle_reg > SCRAP_TIMEOUT_CYC + 4 |-> mode_out != 3'h4) else $error("arming kept past timeout");
  chk_seed_step: assert property (
    seed_req ##1 seed_req |=> seed_out == $past(seed_out) + 8'h01)
    else $error("seed did not advance by one");

  cover property (mode_out == 3'h4);
  cover property (mode_out == 3'h2 && arm);
  cover property ($rose(sequence_error_flag));
endmodule // safing_props
`default_nettype wire

// >>> host_model.sv
// Host controller model: commands, pin levels and sensor responses.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] seed_out,
  output logic            fsm_reset_n,
  output logic            watchdog_fed,
  output logic            control_valid,
  output logic [1:0]      mode_request_field,
  output logic            test_arm,
  output logic            test_n_out_a,
  output logic            thresh_wr,
  output logic [2:0]      thresh_idx,
  output logic [7:0]      thresh_data,
  output logic            seed_req,
  output logic            key_valid,
  output logic [7:0]      key_data,
  output logic            arming_confirm_signal,
  output logic            sync_in,
  output logic            sample_valid,
  output logic            sample_data_ok,
  output logic [2:0]      sequence_id_field,
  output logic [9:0]      sample_data
);
  initial begin
    fsm_reset_n = 1'b1;
    {watchdog_fed, control_valid, thresh_wr, seed_req, key_valid, sync_in, sample_valid} = '0;
    {test_arm, test_n_out_a, arming_confirm_signal, sample_data_ok} = '0;
    {mode_request_field, thresh_idx, thresh_data, key_data, sequence_id_field, sample_data} = '0;
  end

  task automatic strobe(input int k, input logic v);
    case (k)
      0: watchdog_fed <= v;
      1: control_valid <= v;
      2: thresh_wr <= v;
      3: seed_req <= v;
      4: key_valid <= v;
      default: sample_valid <= v;
    endcase
  endtask

  // Released data lines other than thresh_idx show the inverse so stale values can never pass.
  task automatic cmd(input int k, input logic [9:0] d, input logic [2:0] id, input int n);
    @(posedge clk);
    mode_request_field <= d[1:0];
    thresh_idx <= id;
    thresh_data <= d[7:0];
    key_data <= d[7:0];
    sequence_id_field <= id;
    sample_data <= d;
    sample_data_ok <= 1'b1;
    strobe(k, 1'b1);
    repeat (n) @(posedge clk);
    strobe(k, 1'b0);
    {mode_request_field, thresh_data, key_data} <= ~{d[1:0], d[7:0], d[7:0]};
    {sequence_id_field, sample_data, sample_data_ok} <= ~{id, d, 1'b1};
    #1;
  endtask

  task automatic pins(input logic [3:0] v);
    @(posedge clk);
    {fsm_reset_n, arming_confirm_signal, test_arm, test_n_out_a} <= v;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic key(input logic good);
    cmd(3, 10'h000, 3'h0, 1);
    cmd(4, {2'b00, seed_out ^ 8'h55 ^ {7'h00, ~good}}, 3'h0, 1);
  endtask

  task automatic sync_pulse;
    @(posedge clk);
    sync_in <= 1'b1;
    repeat (4) @(posedge clk);
    sync_in <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic period(input logic [9:0] d0);
    sync_pulse();
    cmd(5, d0, 3'h0, 1);
    cmd(5, 10'h000, 3'h1, 1);
  endtask
endmodule // host_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the safing supervisor driven by the host model.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int unsigned TO_CYC = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fsm_reset_n, watchdog_fed, control_valid, test_arm, test_n_out_a, thresh_wr;
  logic seed_req, key_valid, arming_confirm_signal, sync_in, sample_valid, sample_data_ok;
  logic arm, n_out_a, thresh_wr_refused, sequence_error_flag;
  logic [1:0] mode_request_field;
  logic [2:0] thresh_idx, sequence_id_field, mode_out;
  logic [7:0] thresh_data, key_data, seed_out, s0;
  logic [9:0] sample_data;
  logic [3:0] valid_count;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;

  safing_fsm #(.SCRAP_TIMEOUT_CYC(TO_CYC), .DWELL_SHORT_CYC(20), .DWELL_LONG_CYC(40)) dut_u (
    .clk(clk), .rst_n(rst_n), .fsm_reset_n(fsm_reset_n), .watchdog_fed(watchdog_fed),
    .control_valid(control_valid), .mode_request_field(mode_request_field),
    .test_arm(test_arm), .test_n_out_a(test_n_out_a), .thresh_wr(thresh_wr),
    .thresh_idx(thresh_idx), .thresh_data(thresh_data), .seed_req(seed_req),
    .key_valid(key_valid), .key_data(key_data), .arming_confirm_signal(arming_confirm_signal),
    .sync_in(sync_in), .sample_valid(sample_valid), .sample_data_ok(sample_data_ok),
    .sequence_id_field(sequence_id_field), .sample_data(sample_data), .arm(arm),
    .n_out_a(n_out_a), .seed_out(seed_out), .thresh_wr_refused(thresh_wr_refused),
    .sequence_error_flag(sequence_error_flag), .valid_count(valid_count), .mode_out(mode_out));
  host_model host_u (
    .clk(clk), .seed_out(seed_out), .fsm_reset_n(fsm_reset_n), .watchdog_fed(watchdog_fed),
    .control_valid(control_valid), .mode_request_field(mode_request_field),
    .test_arm(test_arm), .test_n_out_a(test_n_out_a), .thresh_wr(thresh_wr),
    .thresh_idx(thresh_idx), .thresh_data(thresh_data), .seed_req(seed_req),
    .key_valid(key_valid), .key_data(key_data), .arming_confirm_signal(arming_confirm_signal),
    .sync_in(sync_in), .sample_valid(sample_valid), .sample_data_ok(sample_data_ok),
    .sequence_id_field(sequence_id_field), .sample_data(sample_data));

  always #10 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_mode(input logic [2:0] m, input int lim);
    for (int i = 0; i < lim && mode_out !== m; i++) begin
      @(posedge clk);
      #1;
    end
    chk("mode_out", m, mode_out);
  endtask

  // A wrong move shows on mode_out two edges after the command; look after three.
  task automatic hold_mode(input logic [2:0] m);
    repeat (3) @(posedge clk);
    #1;
    chk("mode_out", {7'h00, m}, mode_out);
  endtask

  task automatic t_startup;
    chk("mode_out", 10'h000, mode_out);
    chk("arm", 10'h000, arm);
    chk("n_out_a", 10'h001, n_out_a);
    host_u.cmd(5, 10'h050, 3'h0, 1);
    chk("valid_count", 10'h000, valid_count);
    host_u.cmd(2, 10'h0aa, 3'h7, 1);
    chk("thresh_wr_refused", 10'h000, thresh_wr_refused);
    host_u.cmd(0, 10'h000, 3'h0, 1);
    wait_mode(3'h1, 8);
    $display("startup test done");
  endtask

  task automatic t_diag;
    logic [1:0] p;
    for (int i = 0; i < 4; i++) begin
      p = 2'(3 - i);
      host_u.pins({2'b11, p});
      chk("arm", {9'h000, p[1] & p[0]}, arm);
      chk("n_out_a", {9'h000, p[1] & p[0]}, n_out_a);
    end
    host_u.cmd(2, 10'h000, 3'h0, 1);
    chk("thresh_wr_refused", 10'h001, thresh_wr_refused);
    host_u.cmd(1, 10'h000, 3'h0, 4);
    chk("mode_out", 10'h001, mode_out);
    host_u.cmd(1, 10'h002, 3'h0, 1);
    wait_mode(3'h3, 8);
    $display("diagnostic test done");
  endtask

  task automatic t_scrap;
    host_u.period(10'h050);
    chk("valid_count", 10'h000, valid_count);
    host_u.cmd(3, 10'h000, 3'h0, 2);
    s0 = seed_out;
    host_u.cmd(3, 10'h000, 3'h0, 1);
    chk("seed_out", {2'b00, s0 + 8'h02}, seed_out);
    host_u.key(1'b0);
    hold_mode(3'h3);
    host_u.pins(4'b1000);
    host_u.key(1'b1);
    hold_mode(3'h3);
    host_u.pins(4'b1100);
    host_u.key(1'b1);
    wait_mode(3'h4, 8);
    repeat (2) @(posedge clk);
    #1;
    chk("arm", 10'h001, arm);
    chk("n_out_a", 10'h000, n_out_a);
    repeat (30) @(posedge clk);
    host_u.key(1'b1);
    repeat (30) @(posedge clk);
    #1;
    wait_mode(3'h4, 1);
    wait_mode(3'h3, 80);
    repeat (2) @(posedge clk);
    #1;
    chk("arm", 10'h000, arm);
    chk("n_out_a", 10'h001, n_out_a);
    host_u.key(1'b1);
    wait_mode(3'h4, 8);
    host_u.pins(4'b1000);
    wait_mode(3'h3, 8);
    $display("scrap test done");
  endtask

  task automatic t_safing;
    host_u.pins(4'b0000);
    host_u.pins(4'b1000);
    wait_mode(3'h0, 8);
    host_u.cmd(2, 10'h085, 3'h0, 1);
    chk("thresh_wr_refused", 10'h000, thresh_wr_refused);
    host_u.cmd(0, 10'h000, 3'h0, 1);
    wait_mode(3'h1, 8);
    host_u.cmd(1, 10'h001, 3'h0, 1);
    wait_mode(3'h2, 8);
    host_u.cmd(1, 10'h002, 3'h0, 4);
    wait_mode(3'h2, 1);
    for (int p = 0; p < 3; p++) host_u.period(10'h030);
    repeat (4) @(posedge clk);
    #1;
    chk("arm", 10'h001, arm);
    chk("n_out_a", 10'h000, n_out_a);
    chk("valid_count", 10'h002, valid_count);
    host_u.period(10'h000);
    repeat (30) @(posedge clk);
    #1;
    chk("arm", 10'h001, arm);
    for (int i = 0; i < 40 && arm !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk("arm", 10'h000, arm);
    host_u.sync_pulse();
    host_u.cmd(5, 10'h000, 3'h3, 1);
    chk("sequence_error_flag", 10'h001, sequence_error_flag);
    host_u.sync_pulse();
    chk("sequence_error_flag", 10'h000, sequence_error_flag);
    for (int i = 0; i < 16; i++) host_u.cmd(5, 10'h000, 3'(i), 1);
    chk("valid_count", 10'h00f, valid_count);
    $display("safing test done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_startup();
    t_diag();
    t_scrap();
    t_safing();
    summarize();
  end
endmodule // testbench

bind safing_fsm safing_props #(.SCRAP_TIMEOUT_CYC(SCRAP_TIMEOUT_CYC)) props_u (
  .clk(clk), .rst_n(rst_n), .fsm_reset_n(fsm_reset_n), .watchdog_fed(watchdog_fed),
  .seed_req(seed_req), .key_valid(key_valid), .thresh_wr(thresh_wr), .arm(arm),
  .n_out_a(n_out_a), .seed_out(seed_out), .thresh_wr_refused(thresh_wr_refused),
  .sequence_error_flag(sequence_error_flag), .mode_out(mode_out));
`default_nettype wire
